// ===== hdl/hsr_regs.sv
// Result and status registers with a two-wire bus slave on the link clock.
// Assumes sample and fault pulses come from logic on clk_in; the bus pins
// and the alert pin are asynchronous and pass three flip-flops.

// Summary of operation
// - Temperature low byte returns bits 7-0 of latest result, zero after reset.
// - X result read as high byte then low byte at two offsets.
// - Y result read as high byte then low byte at two offsets.
// - Z result read as high byte then low byte at two offsets.
// - Top three bits of conversion state hold a rolling set count.
// - Power-on flag set by reset, cleared when host writes one.
// - Diagnostic bit shows any of the four fault flags set.
// - Ready bit set when a full set is buffered, cleared when a new conversion starts.
// - Heading uses 13 low bits, lowest four hold sixteenths of degree.
// - Vector length is an eight-bit read-only byte.
// - Alert readback bit follows alert pin level, reset value one.
// - Clock fault flag is sticky, cleared by writing one.
// - Alert line fault flag is sticky, cleared by writing one.
// - Fuse memory check fault flag is sticky, cleared by writing one.
// - Supply low flag is sticky, cleared by writing one.
// - Temperature high byte sits just before the low byte.
module hsr_regs
  import hsr_pkg::*;
(
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  input  wire logic                 ce_in,
  input  wire logic                 link_clk_in,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_n_out,
  input  wire logic                 alert_pin_in,
  input  wire hsr_pkg::hsr_sample_t sample_in,
  input  wire logic                 sample_valid_in,
  input  wire logic                 conv_start_in,
  input  wire hsr_pkg::hsr_fault_t  fault_evt_in,
  output logic                      conv_ready_out,
  output logic                      diag_fail_out
);
  import hsr_pkg::*;

  // Reads a byte of the register image, zero outside the map
  function automatic logic [7:0] img_byte(input hsr_image_t img,
                                          input logic [7:0] ptr);
    logic [7:0] idx;
    idx = ptr - OFS_TEMP_HIGH;
    if (ptr >= OFS_TEMP_HIGH && ptr <= OFS_HEALTH)
      img_byte = img[idx[3:0]];
    else
      img_byte = 8'h00;
  endfunction

  // ---------------- core domain ----------------
  hsr_sample_t  sample;
  logic [2:0]   set_count;
  logic         power_on;
  logic         conv_ready;
  hsr_fault_t   faults;
  logic [2:0]   alert_sync;
  logic         alert_rb;
  logic [2:0]   wr_sync;
  logic         wr_seen;
  logic         wr_evt;
  logic         img_req_tog;
  logic [2:0]   img_ack_sync;
  hsr_image_t   img_hold;
  hsr_image_t   next_image;
  logic [7:0]   wr_addr;
  logic [7:0]   wr_data;
  logic         wr_tog;
  logic         img_ack_tog;
  logic [7:0]   conv_byte;
  logic [7:0]   health_byte;
  logic         diag_any;

  // Write event arrives as a toggle once two late stages agree
  assign wr_evt = (wr_sync[1] == wr_sync[2]) && (wr_sync[2] != wr_seen);
  assign diag_any = |faults;

  // Pin and toggle synchronisers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      alert_sync   <= 3'h7;
      wr_sync      <= 3'h0;
      img_ack_sync <= 3'h0;
    end else if (ce_in) begin
      alert_sync   <= {alert_sync[1:0], alert_pin_in};
      wr_sync      <= {wr_sync[1:0], wr_tog};
      img_ack_sync <= {img_ack_sync[1:0], img_ack_tog};
    end
  end

  // Alert line readback follows the filtered pin
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      alert_rb <= RST_ALERT_RB;
    end else if (ce_in && alert_sync[1] == alert_sync[2]) begin
      alert_rb <= alert_sync[2];
    end
  end

  // Conversion results load as one set
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sample <= '0;
    end else if (ce_in && sample_valid_in) begin
      sample <= sample_in;
    end
  end

  // Ready flag and rolling set count
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      conv_ready <= 1'b0;
      set_count  <= RST_SET_COUNT;
    end else if (ce_in) begin
      if (sample_valid_in) begin
        conv_ready <= 1'b1;
        set_count  <= set_count + 3'h1;
      end else if (conv_start_in) begin
        conv_ready <= 1'b0;
      end
    end
  end

  // Power-on flag, set only by reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      power_on <= RST_POWER_ON;
    end else if (ce_in && wr_evt && wr_addr == OFS_CONV_STATE &&
                 wr_data[POS_POWER_ON]) begin
      power_on <= 1'b0;
    end
  end

  // Sticky fault flags, a new event beats a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      faults <= RST_FAULTS;
    end else if (ce_in) begin
      if (wr_evt && wr_addr == OFS_HEALTH) begin
        faults <= (faults & ~wr_data[POS_CLOCK_FAULT:POS_SUPPLY_LOW])
                  | fault_evt_in;
      end else begin
        faults <= faults | fault_evt_in;
      end
    end
  end

  // Write toggle has been consumed
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_seen <= 1'b0;
    end else if (ce_in && wr_evt) begin
      wr_seen <= wr_sync[2];
    end
  end

  // Register image as the bus sees it
  always_comb begin
    conv_byte = 8'h00;
    conv_byte[7:POS_SET_COUNT_LO] = set_count;
    conv_byte[POS_POWER_ON]       = power_on;
    conv_byte[POS_DIAG_FAIL]      = diag_any;
    conv_byte[POS_CONV_READY]     = conv_ready;
    health_byte = 8'h00;
    health_byte[POS_ALERT_RB]    = alert_rb;
    health_byte[POS_CLOCK_FAULT] = faults.clock_fault;
    health_byte[POS_ALERT_FAULT] = faults.alert_line_fault;
    health_byte[POS_FUSE_FAULT]  = faults.fuse_memory_check_fault;
    health_byte[POS_SUPPLY_LOW]  = faults.supply_low;
    next_image = '0;
    next_image[0]  = sample.temperature_sample[15:8];
    next_image[1]  = sample.temperature_sample[7:0];
    next_image[2]  = sample.field_x_sample[15:8];
    next_image[3]  = sample.field_x_sample[7:0];
    next_image[4]  = sample.field_y_sample[15:8];
    next_image[5]  = sample.field_y_sample[7:0];
    next_image[6]  = sample.field_z_sample[15:8];
    next_image[7]  = sample.field_z_sample[7:0];
    next_image[8]  = conv_byte;
    next_image[9]  = {3'h0, sample.heading[HEAD_BITS-1:8]};
    next_image[10] = sample.heading[7:0];
    next_image[11] = sample.vector_length;
    next_image[12] = health_byte;
  end

  // Image handed to the link domain when the last one was taken
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      img_hold    <= '0;
      img_req_tog <= 1'b0;
    end else if (ce_in && img_ack_sync[1] == img_ack_sync[2] &&
                 img_ack_sync[2] == img_req_tog) begin
      img_hold    <= next_image;
      img_req_tog <= ~img_req_tog;
    end
  end

  // Status outputs
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      conv_ready_out <= 1'b0;
      diag_fail_out  <= 1'b0;
    end else if (ce_in) begin
      conv_ready_out <= conv_ready;
      diag_fail_out  <= diag_any;
    end
  end

  // ---------------- link domain ----------------
  logic [1:0]      rst_link_sync;
  logic            link_rstn;
  logic [3:0]      s1;
  logic [3:0]      s2;
  logic [3:0]      s3;
  logic [3:0]      filt;
  logic [3:0]      filt_d;
  logic            scl_f;
  logic            sda_f;
  logic            link_ce;
  logic            img_seen;
  hsr_image_t      img_link;
  hsr_link_state_t state;
  logic [3:0]      bit_cnt;
  logic [7:0]      shreg;
  logic [7:0]      ptr;
  logic            rd_dir;
  logic            ack_ok;
  logic            drive_n;
  logic [7:0]      tx_byte;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_cond;
  logic            stop_cond;

  assign link_rstn  = rst_link_sync[1];
  assign scl_f      = filt[0];
  assign sda_f      = filt[1];
  assign link_ce    = filt[3];
  assign scl_rise   = scl_f & ~filt_d[0];
  assign scl_fall   = ~scl_f & filt_d[0];
  assign start_cond = scl_f & filt_d[0] & ~sda_f & filt_d[1];
  assign stop_cond  = scl_f & filt_d[0] & sda_f & ~filt_d[1];
  assign tx_byte    = img_byte(img_link, ptr);

  // Reset release into the link domain
  always_ff @(posedge link_clk_in) begin
    rst_link_sync <= {rst_link_sync[0], rstn_in};
  end

  // Three-stage synchronisers, a change counts when two late stages agree
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      s1     <= 4'hB;
      s2     <= 4'hB;
      s3     <= 4'hB;
      filt   <= 4'hB;
      filt_d <= 4'hB;
    end else begin
      s1     <= {ce_in, img_req_tog, sda_in, scl_in};
      s2     <= s1;
      s3     <= s2;
      filt   <= (s2 & s3) | (filt & (s2 ^ s3));
      filt_d <= filt;
    end
  end

  // Take a fresh register image
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      img_link    <= '0;
      img_seen    <= 1'b0;
      img_ack_tog <= 1'b0;
    end else if (link_ce && filt[2] != img_seen) begin
      img_link    <= img_hold;
      img_seen    <= filt[2];
      img_ack_tog <= filt[2];
    end
  end

  // Two-wire bus slave with auto-incrementing register pointer
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      state   <= L_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      ptr     <= 8'h00;
      rd_dir  <= 1'b0;
      ack_ok  <= 1'b0;
      drive_n <= 1'b1;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_tog  <= 1'b0;
    end else if (link_ce) begin
      if (start_cond) begin
        state   <= L_ADDR;
        bit_cnt <= 4'h0;
        drive_n <= 1'b1;
      end else if (stop_cond) begin
        state   <= L_IDLE;
        drive_n <= 1'b1;
      end else if (scl_rise) begin
        if (state == L_ADDR || state == L_PTR || state == L_WDATA) begin
          shreg   <= {shreg[6:0], sda_f};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (state == L_RACK) begin
          ack_ok  <= ~sda_f;
        end
      end else if (scl_fall) begin
        unique case (state)
          L_IDLE: begin
          end
          L_ADDR: if (bit_cnt == BYTE_BITS) begin
            if (shreg[7:1] == DEV_ADDR) begin
              rd_dir  <= shreg[0];
              drive_n <= 1'b0;
              state   <= L_AACK;
            end else begin
              state   <= L_IDLE;
            end
          end
          L_PTR: if (bit_cnt == BYTE_BITS) begin
            ptr     <= shreg;
            drive_n <= 1'b0;
            state   <= L_PACK;
          end
          L_WDATA: if (bit_cnt == BYTE_BITS) begin
            wr_addr <= ptr;
            wr_data <= shreg;
            wr_tog  <= ~wr_tog;
            ptr     <= ptr + 8'h01;
            drive_n <= 1'b0;
            state   <= L_WACK;
          end
          L_AACK: begin
            if (rd_dir) begin
              shreg   <= tx_byte;
              drive_n <= tx_byte[7];
              bit_cnt <= 4'h1;
              state   <= L_RDATA;
            end else begin
              drive_n <= 1'b1;
              bit_cnt <= 4'h0;
              state   <= L_PTR;
            end
          end
          L_PACK, L_WACK: begin
            drive_n <= 1'b1;
            bit_cnt <= 4'h0;
            state   <= L_WDATA;
          end
          L_RDATA: begin
            if (bit_cnt == BYTE_BITS) begin
              drive_n <= 1'b1;
              ptr     <= ptr + 8'h01;
              state   <= L_RACK;
            end else begin
              drive_n <= shreg[6];
              shreg   <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          L_RACK: begin
            if (ack_ok) begin
              shreg   <= tx_byte;
              drive_n <= tx_byte[7];
              bit_cnt <= 4'h1;
              state   <= L_RDATA;
            end else begin
              drive_n <= 1'b1;
              state   <= L_IDLE;
            end
          end
          // Unused codes fall back to idle with the line released
          default: begin
            drive_n <= 1'b1;
            state   <= L_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain data pin, only ever pulls low
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      sda_out      <= 1'b0;
      sda_oe_n_out <= 1'b1;
    end else begin
      sda_out      <= 1'b0;
      sda_oe_n_out <= drive_n;
    end
  end

endmodule

// ===== hdl/hsr_pkg.sv
// Package for the hall sensor result and status register block.
// Assumes one core clock, one link clock and an open-drain two-wire bus.
package hsr_pkg;

  // Register offsets on the two-wire bus
  localparam logic [7:0] OFS_TEMP_HIGH   = 8'h10;
  localparam logic [7:0] OFS_TEMP_LOW    = 8'h11;
  localparam logic [7:0] OFS_X_HIGH      = 8'h12;
  localparam logic [7:0] OFS_X_LOW       = 8'h13;
  localparam logic [7:0] OFS_Y_HIGH      = 8'h14;
  localparam logic [7:0] OFS_Y_LOW       = 8'h15;
  localparam logic [7:0] OFS_Z_HIGH      = 8'h16;
  localparam logic [7:0] OFS_Z_LOW       = 8'h17;
  localparam logic [7:0] OFS_CONV_STATE  = 8'h18;
  localparam logic [7:0] OFS_HEAD_HIGH   = 8'h19;
  localparam logic [7:0] OFS_HEAD_LOW    = 8'h1A;
  localparam logic [7:0] OFS_VEC_LENGTH  = 8'h1B;
  localparam logic [7:0] OFS_HEALTH      = 8'h1C;
  localparam int         IMG_BYTES       = 13;

  // Conversion state fields
  localparam int POS_SET_COUNT_LO = 5;
  localparam int POS_POWER_ON     = 4;
  localparam int POS_DIAG_FAIL    = 1;
  localparam int POS_CONV_READY   = 0;
  // Health flag fields
  localparam int POS_ALERT_RB     = 4;
  localparam int POS_CLOCK_FAULT  = 3;
  localparam int POS_ALERT_FAULT  = 2;
  localparam int POS_FUSE_FAULT   = 1;
  localparam int POS_SUPPLY_LOW   = 0;

  // Reset values
  localparam logic [2:0] RST_SET_COUNT = 3'h0;
  localparam logic       RST_POWER_ON  = 1'b1;
  localparam logic       RST_ALERT_RB  = 1'b1;
  localparam logic [3:0] RST_FAULTS    = 4'h0;

  // Bus address of this device, value arbitrary
  localparam logic [6:0] DEV_ADDR      = 7'h2A;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam int         HEAD_BITS     = 13;

  // One finished conversion set
  typedef struct packed {
    logic [15:0] temperature_sample;
    logic [15:0] field_x_sample;
    logic [15:0] field_y_sample;
    logic [15:0] field_z_sample;
    logic [12:0] heading;
    logic [7:0]  vector_length;
  } hsr_sample_t;

  // Fault detector pulses
  typedef struct packed {
    logic clock_fault;
    logic alert_line_fault;
    logic fuse_memory_check_fault;
    logic supply_low;
  } hsr_fault_t;

  typedef logic [IMG_BYTES-1:0][7:0] hsr_image_t;

  typedef enum logic [3:0] {
    L_IDLE, L_ADDR, L_AACK, L_PTR, L_PACK, L_WDATA, L_WACK, L_RDATA, L_RACK
  } hsr_link_state_t;

endpackage

// ===== test/hsr_regs_props.sv
// Checker for the result and status register block.
// Assumes it is bound to hsr_regs and sees only its ports.
module hsr_regs_props
  import hsr_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rstn_in,
  input  wire logic                link_clk_in,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  input  wire logic                sda_oe_n_out,
  input  wire logic                sample_valid_in,
  input  wire logic                conv_start_in,
  input  wire hsr_pkg::hsr_fault_t fault_evt_in,
  input  wire logic                conv_ready_out,
  input  wire logic                diag_fail_out
);
  logic [7:0] idle_cnt;
  logic [2:0] evt_hist;
  logic [2:0] vld_hist;

  // Bus idle time and recent causes of the two flags
  always_ff @(posedge clk_in) begin
    if (!rstn_in || !scl_in || !sda_in) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hC8) idle_cnt <= idle_cnt + 8'h01;
  end
  always_ff @(posedge clk_in) begin
    evt_hist <= rstn_in ? {evt_hist[1:0], |fault_evt_in} : 3'h0;
    vld_hist <= rstn_in ? {vld_hist[1:0], sample_valid_in} : 3'h0;
  end

  a_ready_set: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    sample_valid_in |-> ##[1:3] conv_ready_out)
    else $error("ready not raised after a sample");
  a_ready_clear: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    conv_start_in && !sample_valid_in |-> ##[1:3] !conv_ready_out)
    else $error("ready not dropped after a start");
  a_ready_cause: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(conv_ready_out) |-> vld_hist != 3'h0)
    else $error("ready rose without a sample");
  a_diag_set: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    |fault_evt_in |-> ##[1:3] diag_fail_out)
    else $error("diag not raised after a fault");
  a_diag_cause: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(diag_fail_out) |-> evt_hist != 3'h0)
    else $error("diag rose without a fault");
  a_flags_sticky: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    idle_cnt == 8'hC8 && $past(diag_fail_out) |-> diag_fail_out)
    else $error("fault flag dropped with the bus idle");
  a_reset_quiet: assert property (
    @(posedge clk_in) disable iff (!rstn_in)
    $rose(rstn_in) |-> !conv_ready_out && !diag_fail_out)
    else $error("flags not zero after reset");
  a_ack_scl_low: assert property (
    @(posedge link_clk_in) disable iff (!rstn_in)
    $changed(sda_oe_n_out) |-> !scl_in)
    else $error("data line changed while bus clock high");
endmodule

bind hsr_regs hsr_regs_props u_props (
  .clk_in, .rstn_in, .link_clk_in, .scl_in, .sda_in, .sda_oe_n_out,
  .sample_valid_in, .conv_start_in, .fault_evt_in, .conv_ready_out,
  .diag_fail_out
);

// ===== test/hsr_host_model.sv
// Host model: bus master on the two-wire pins, timed by delays.
// Assumes the bench resolves the open-drain data wire with a pull-up.
module hsr_host_model
  import hsr_pkg::*;
(
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TQ = 250;
  logic [7:0] rx [0:15];
  logic       nack;

  // Bus clock stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    nack = 1'b0;
  end

  // Data set while the clock is low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    sda_out = b;
    #TQ scl_out = 1'b1;
    #TQ s = sda_in;
    #TQ scl_out = 1'b0;
    #TQ;
  endtask
  task automatic start_cond();
    sda_out = 1'b1;
    #TQ scl_out = 1'b1;
    #TQ sda_out = 1'b0;
    #TQ scl_out = 1'b0;
    #TQ;
  endtask
  task automatic stop_cond();
    sda_out = 1'b0;
    #TQ scl_out = 1'b1;
    #TQ sda_out = 1'b1;
    #TQ;
  endtask
  // Missing acknowledges collect in nack
  task automatic put_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    nack = nack | s;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, s);
  endtask
  // A one written to a sticky flag clears it
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
    nack = 1'b0;
    start_cond();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(ptr);
    put_byte(d);
    stop_cond();
  endtask
  // Burst read, last byte not acknowledged
  task automatic read_seq(input logic [7:0] ptr, input int n);
    nack = 1'b0;
    start_cond();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(ptr);
    start_cond();
    put_byte({DEV_ADDR, 1'b1});
    for (int k = 0; k < n; k++) get_byte(k == n - 1, rx[k]);
    stop_cond();
  endtask
endmodule

// ===== test/tb_hall_sensor_result_status_regs.sv
// Testbench for the result and status register block.
// Assumes the host model on the bus pins and a free 64 ns link clock.
module tb_hall_sensor_result_status_regs
  import hsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        link_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        sample_valid_in = 1'b0;
  logic        conv_start_in = 1'b0;
  logic        alert_pin_in = 1'b1;
  hsr_sample_t sample_in = '0;
  hsr_fault_t  fault_evt_in = '0;
  logic        host_scl, host_sda, sda_out, sda_oe_n_out, sda_wire;
  logic        conv_ready_out, diag_fail_out;
  int          error_cnt = 0;
  int          samples_checked = 0;

  // Clocks share an edge every 160 ns; data wire is wired-AND
  always #5 clk_in = ~clk_in;
  always #32 link_clk_in = ~link_clk_in;
  assign sda_wire = host_sda & (sda_oe_n_out | sda_out);

  hsr_regs dut (
    .clk_in, .rstn_in, .ce_in(1'b1), .link_clk_in, .scl_in(host_scl),
    .sda_in(sda_wire), .sda_out, .sda_oe_n_out, .alert_pin_in, .sample_in,
    .sample_valid_in, .conv_start_in, .fault_evt_in, .conv_ready_out,
    .diag_fail_out
  );
  hsr_host_model host (
    .scl_out (host_scl),
    .sda_out (host_sda),
    .sda_in  (sda_wire)
  );

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("TB: checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Reset map with an unmapped byte at each end
  task automatic t_reset();
    host.read_seq(8'h0F, 15);
    chk("ack", 8'h00, {7'h00, host.nack});
    for (int k = 0; k < 15; k++)
      chk("reset", (k == 9 || k == 13) ? 8'h10 : 8'h00, host.rx[k]);
    $display("TB: reset map done");
  endtask
  // Nine sets wrap the count to one; whole image read back in order
  task automatic t_sample();
    logic [103:0] img;
    img = {64'hA1B2_C3D4_E5F6_0718, 8'h31, 16'h1ABC, 8'h9E, 8'h10};
    sample_in = '{16'hA1B2, 16'hC3D4, 16'hE5F6, 16'h0718, 13'h1ABC, 8'h9E};
    repeat (9) begin
      sample_valid_in = 1'b1;
      wait_clk(1);
      sample_valid_in = 1'b0;
      wait_clk(1);
    end
    wait_clk(3);
    chk("ready", 8'h01, {7'h00, conv_ready_out});
    wait_clk(200);
    host.read_seq(8'h10, 13);
    chk("ack", 8'h00, {7'h00, host.nack});
    for (int k = 0; k < 13; k++)
      chk("image", img[(12 - k) * 8 +: 8], host.rx[k]);
    $display("TB: sample image done");
  endtask
  // Start of a new set drops ready; zero and read-only writes ignored
  task automatic t_status();
    conv_start_in = 1'b1;
    wait_clk(1);
    conv_start_in = 1'b0;
    wait_clk(3);
    chk("ready", 8'h00, {7'h00, conv_ready_out});
    host.write_reg(8'h18, 8'h00);
    chk("ack", 8'h00, {7'h00, host.nack});
    wait_clk(200);
    host.read_seq(8'h18, 1);
    chk("conv zero wr", 8'h30, host.rx[0]);
    host.write_reg(8'h18, 8'hFF);
    chk("ack", 8'h00, {7'h00, host.nack});
    wait_clk(200);
    host.read_seq(8'h18, 1);
    chk("conv ones wr", 8'h20, host.rx[0]);
    $display("TB: status done");
  endtask
  // Each fault flag raised, seen in both registers, then cleared
  task automatic t_faults();
    logic [3:0] mask;
    for (int i = 0; i < 4; i++) begin
      mask = 4'h1 << i;
      alert_pin_in = i[0];
      fault_evt_in = mask;
      wait_clk(1);
      fault_evt_in = '0;
      wait_clk(3);
      chk("diag", 8'h01, {7'h00, diag_fail_out});
      wait_clk(200);
      host.read_seq(8'h18, 5);
      chk("diag bit", 8'h22, host.rx[0]);
      chk("health", {3'h0, i[0], mask}, host.rx[4]);
      host.write_reg(8'h1C, {4'h0, mask});
      chk("ack", 8'h00, {7'h00, host.nack});
      wait_clk(20);
      chk("diag clr", 8'h00, {7'h00, diag_fail_out});
    end
    $display("TB: faults done");
  endtask

  initial begin
    repeat (8) @(posedge link_clk_in);
    wait_clk(1);
    rstn_in = 1'b1;
    wait_clk(200);
    t_reset();
    t_sample();
    t_status();
    t_faults();
    stop_test();
  end
  // Watchdog
  initial begin
    #950_000;
    error_cnt++;
    stop_test();
  end
endmodule
